// ### core/rcs_pkg.sv
package rcs_pkg;

    // ****************************************************************
    // Strap layout
    // ****************************************************************
    localparam int unsigned CFG_WIDTH = 16;
    // Pins without a default pull-up (PLL ratio straps)
    localparam logic [CFG_WIDTH-1:0] NO_PULL_MASK = 16'h00ff;
    // Default strap value: a high level selects each default
    localparam logic [CFG_WIDTH-1:0] CFG_RESET_VAL = 16'hffff;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned HOLD_TIME_NS = 80;
    localparam int unsigned HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 8;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_RESET,
        ST_HOLD,
        ST_RUN
    } rcs_state_t;

    // Pin-side control bundle for the strap pads
    typedef struct packed {
        logic [CFG_WIDTH-1:0] oe;
        logic [CFG_WIDTH-1:0] rx_en;
        logic [CFG_WIDTH-1:0] pu_en;
    } rcs_pad_ctl_t;

endpackage : rcs_pkg

// ### core/rcs_strap_capture.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Out of reset, strap pins are driven as normal function outputs.
// R2 - During hard reset, strap pins are inputs fed to capture logic.
// R3 - Latch pins at reset release, then disable receivers, restore function; the block latches at the end of the post-release window.
// R4 - Pull-up on only during reset plus short window, off with receiver.
// R5 - High sampled level means default; board pulls low for non-default.
// R6 - PLL ratio pins get no pull-up; board must drive them.
// R7 - Post-release window length is a parameter; captured values hold until next reset.
module rcs_strap_capture
    import rcs_pkg::*;
#(
    parameter int unsigned HOLD_CNT = HOLD_CYCLES
) (
    // Clock and hard reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Strap pins
    input wire logic [CFG_WIDTH-1:0] CFG_PIN_I,
    output var logic [CFG_WIDTH-1:0] CFG_PIN_O,
    output var logic [CFG_WIDTH-1:0] CFG_PIN_OE,
    output var logic [CFG_WIDTH-1:0] CFG_PIN_RX_EN,
    output var logic [CFG_WIDTH-1:0] CFG_PIN_PU_EN,
    // Normal function drive
    input wire logic [CFG_WIDTH-1:0] FUNC_OUT,
    // Captured configuration
    output var logic [CFG_WIDTH-1:0] CFG_VALUE,
    output var logic CFG_VALID
);

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    logic [CFG_WIDTH-1:0] sync1_q, sync1_d;
    logic [CFG_WIDTH-1:0] sync2_q, sync2_d;

    // First stage reads the pins, the second reads only the first
    always_comb begin
        sync1_d = CFG_PIN_I;
        sync2_d = sync1_q;
    end

    // No reset on purpose: the pins must be tracked while the hard reset
    // is held, so the capture sees the strap level and not a stand-in
    always_ff @(posedge CORE_CLK) begin
        sync1_q <= sync1_d; // [R2]
        sync2_q <= sync2_d;
    end

    // ****************************************************************
    // Capture sequencer
    // ****************************************************************
    rcs_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CFG_WIDTH-1:0] cfg_q, cfg_d;
    logic valid_q, valid_d;
    rcs_pad_ctl_t pad_q, pad_d;

    // Pull-up mask honours the pins that have no on-chip pull-up
    function automatic logic [CFG_WIDTH-1:0] pu_mask(input logic on);
        pu_mask = on ? ~NO_PULL_MASK : '0; // [R6]
    endfunction : pu_mask

    // Next-state: receivers and pull-ups stay on through the window so
    // the synchroniser has settled on the real strap level before latching
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cfg_d = cfg_q;
        valid_d = valid_q;
        pad_d = pad_q;
        case (state_q)
            ST_RESET: begin
                state_d = ST_HOLD;
                cnt_d = '0;
            end
            ST_HOLD: begin
                // A HOLD_CNT of zero wraps the compare to the longest window
                if (cnt_q >= CNT_W'(HOLD_CNT - 1)) begin // [R7]
                    cfg_d = sync2_q; // [R3] [R5]
                    valid_d = 1'b1;
                    pad_d.rx_en = '0; // [R3]
                    pad_d.pu_en = pu_mask(1'b0); // [R4]
                    pad_d.oe = '1; // [R1]
                    state_d = ST_RUN;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            ST_RUN: begin
                // Values hold until the next hard reset
                // Only the hard reset leaves this state
                state_d = ST_RUN; // [R7]
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    // Registers; reset puts pins in input mode with gated pull-ups
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_RESET;
            cnt_q <= '0;
            cfg_q <= CFG_RESET_VAL;
            valid_q <= 1'b0;
            pad_q.oe <= '0; // [R2]
            pad_q.rx_en <= '1; // [R2]
            pad_q.pu_en <= ~NO_PULL_MASK; // [R4] [R6]
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cfg_q <= cfg_d;
            valid_q <= valid_d;
            pad_q <= pad_d;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    logic [CFG_WIDTH-1:0] dout_q, dout_d;

    // Function data only reaches the pad once the strap phase is over;
    // until then the data register idles at zero, so nothing stale
    // from before a mid-run reset is left waiting on the pad
    always_comb begin
        dout_d = valid_q ? FUNC_OUT : '0; // [R1]
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dout_q <= '0;
        end else begin
            dout_q <= dout_d;
        end
    end

    // Outputs straight from flip-flops
    // Plain wires to the ports; every source here is a register
    always_comb begin
        CFG_PIN_O = dout_q;
        CFG_PIN_OE = pad_q.oe;
        CFG_PIN_RX_EN = pad_q.rx_en;
        CFG_PIN_PU_EN = pad_q.pu_en;
        CFG_VALUE = cfg_q;
        CFG_VALID = valid_q;
    end

    // ****************************************************************
    // Checker helpers
    // ****************************************************************
    // Cycles since the hard reset let go, kept apart from the sequencer's
    // own counter so the window check does not lean on what it checks;
    // it saturates so a long run never wraps back into the window
    logic [CNT_W:0] since_rel_q, since_rel_d;

    // Next count, held once it reaches the top
    always_comb begin
        since_rel_d = since_rel_q;
        if (since_rel_q != '1) begin
            since_rel_d = since_rel_q + (CNT_W+1)'(1);
        end
    end

    // Cleared by the hard reset like the sequencer it watches
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            since_rel_q <= '0;
        end else begin
            since_rel_q <= since_rel_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // One clock domain, so one default clock and reset for all checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    // Strap phase: pins listen, pull-ups only where one is fitted
    a_no_drive_in_strap: assert property (!valid_q |-> (pad_q.oe == '0 && pad_q.rx_en == '1)) // [R2]
        else $error("Strap pin driven before capture");
    a_pullup_strap: assert property (!valid_q |-> pad_q.pu_en == pu_mask(1'b1)) // [R4] [R6]
        else $error("Pull-up not on during strap phase");
    a_pin_quiet: assert property (!valid_q |-> dout_q == '0) // [R2]
        else $error("Pad data not quiet during strap phase");
    a_pll_no_pull: assert property ((pad_q.pu_en & NO_PULL_MASK) == '0) // [R6]
        else $error("Pull-up on a PLL ratio pin");
    a_pull_needs_rx: assert property ((pad_q.pu_en & ~pad_q.rx_en) == '0) // [R4]
        else $error("Pull-up on where the receiver is off");

    // Capture: value, timing and what follows it
    a_cap_value: assert property ($rose(valid_q) |-> cfg_q == $past(sync2_q)) // [R3] [R5]
        else $error("Captured value differs from pin level");
    a_window_len: assert property ($rose(valid_q) |-> since_rel_q == (CNT_W+1)'(HOLD_CNT + 1)) // [R7]
        else $error("Hold window length wrong");
    a_window_bound: assert property (since_rel_q == (CNT_W+1)'(HOLD_CNT + 1) |-> valid_q) // [R3] [R7]
        else $error("Capture missing at window end");
    a_cap_stable: assert property (valid_q |=> ($stable(cfg_q) && valid_q)) // [R7]
        else $error("Captured value changed after capture");

    // Function phase: pins drive, receivers and pull-ups off
    a_drive_after_cap: assert property (valid_q |-> (pad_q.oe == '1 && pad_q.rx_en == '0)) // [R1] [R3]
        else $error("Strap pin not returned to function");
    a_pullup_with_rx: assert property (valid_q |-> pad_q.pu_en == '0) // [R4]
        else $error("Pull-up left on after capture");
    a_func_drive: assert property (valid_q |=> CFG_PIN_O == $past(FUNC_OUT)) // [R1]
        else $error("Function data not on pad");

    // Main scenarios
    c_capture: cover property ($rose(valid_q));
    c_nondefault: cover property ($rose(valid_q) ##0 cfg_q != CFG_RESET_VAL);
    c_default: cover property ($rose(valid_q) ##0 cfg_q == CFG_RESET_VAL);
    c_pll_low: cover property ($rose(valid_q) ##0 (cfg_q & NO_PULL_MASK) != NO_PULL_MASK);

endmodule : rcs_strap_capture
`default_nettype wire

// ### bench/rcs_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Board straps
// ****
module rcs_board_model
    import rcs_pkg::*;
(
    // Strap resistors on the board
    input wire logic [CFG_WIDTH-1:0] strap_val,
    input wire logic [CFG_WIDTH-1:0] strap_en,
    // Device pad side
    input wire logic [CFG_WIDTH-1:0] pad_o,
    input wire logic [CFG_WIDTH-1:0] pad_oe,
    input wire logic [CFG_WIDTH-1:0] pad_pu,
    output var logic [CFG_WIDTH-1:0] pad_i
);
    logic flt_q = 1'b0;
    // Floating pins wander so an unpulled pin never reads a steady level
    always #7 flt_q = ~flt_q;
    // Driver wins, then the strong strap, then the weak gated pull-up
    assign pad_i = (pad_oe & pad_o) | (~pad_oe & strap_en & strap_val)
        | (~pad_oe & ~strap_en & (pad_pu | {CFG_WIDTH{flt_q}}));
endmodule : rcs_board_model
`default_nettype wire

// ### bench/reset_config_strap_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Strap capture bench
// ****
module reset_config_strap_capture_tb_top;
    import rcs_pkg::*;
    localparam int HC = 2;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] func, sval, sen, pin_i, pin_o, oe, rx, pu, val, ev;
    logic valid;
    int n_mismatch = 0;
    int total_checks = 0;
    int n;
    logic [31:0] seed = 32'h19fd9fe2;
    always #5 clk = ~clk;
    rcs_strap_capture #(.HOLD_CNT(HC)) dut (.CORE_CLK(clk), .RSTN(rstn), .CFG_PIN_I(pin_i),
        .CFG_PIN_O(pin_o), .CFG_PIN_OE(oe), .CFG_PIN_RX_EN(rx), .CFG_PIN_PU_EN(pu),
        .FUNC_OUT(func), .CFG_VALUE(val), .CFG_VALID(valid));
    rcs_board_model brd (.strap_val(sval), .strap_en(sen), .pad_o(pin_o), .pad_oe(oe),
        .pad_pu(pu), .pad_i(pin_i));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // Board drives straps where fitted; elsewhere the pull-up reads high
    function automatic logic [15:0] exp_cap(input logic [15:0] v, input logic [15:0] e);
        return (e & v) | ~e;
    endfunction : exp_cap
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    // Watchdog: the passes take about 150 cycles, this allows 20000
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
    // Each pass is one full reset, window and capture cycle
    initial begin
        func = 16'h0000;
        sval = 16'hffff;
        sen = 16'h00ff;
        repeat (20) @(negedge clk);
        for (int t = 0; t < 12; t++) begin
            rstn = 1'b0;
            seed = xs(seed);
            sval = (t == 0) ? 16'hffff : (t == 1) ? 16'h0000 : seed[15:0];
            sen = (t < 2) ? 16'hffff : (NO_PULL_MASK | seed[31:16]);
            ev = exp_cap(sval, sen);
            repeat (3) @(negedge clk);
            chk("oe_rst", 16'h0000, oe);
            chk("rx_rst", 16'hffff, rx);
            chk("pu_rst", ~NO_PULL_MASK, pu);
            chk("vld_rst", 16'h0000, {15'h0, valid});
            chk("pin_o_rst", 16'h0000, pin_o);
            chk("val_rst", CFG_RESET_VAL, val);
            rstn = 1'b1;
            n = 0;
            while (valid !== 1'b1 && n < 20) begin
                @(negedge clk);
                n++;
                if (n == 1) begin
                    chk("pu_win", ~NO_PULL_MASK, pu);
                    chk("rx_win", 16'hffff, rx);
                end
            end
            chk("latency", 16'(1 + HC), n[15:0]);
            chk("value", ev, val);
            chk("oe_run", 16'hffff, oe);
            chk("rx_run", 16'h0000, rx);
            chk("pu_run", 16'h0000, pu);
            seed = xs(seed);
            func = seed[15:0];
            sval = ~sval;
            @(negedge clk);
            chk("pin_o", func, pin_o);
            repeat (4) @(negedge clk);
            chk("value_hold", ev, val);
            $display("test %0d done", t);
        end
        results();
    end
endmodule : reset_config_strap_capture_tb_top
`default_nettype wire
